// ==== pmr_result_bank.v ====
// Purpose: coefficient register and read-only result registers
// Assumes: register access is by address, write and read strobes
// Notes: read data registered, two cycles after the read strobe
`include "pmr_defs.vh"
`default_nettype none

module pmr_result_bank (
  // clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // register access
  input wire [7:0] i_addr,
  input wire i_wr_en,
  input wire [15:0] i_wr_data,
  input wire i_rd_en,
  // measurement path
  input wire i_range_select,
  input wire [14:0] i_shunt_cal,
  input wire i_shunt_valid,
  input wire [19:0] i_shunt_code,
  input wire i_bus_valid,
  input wire [19:0] i_bus_code,
  input wire i_temp_valid,
  input wire [15:0] i_temp_code,
  input wire i_power_valid,
  input wire [23:0] i_power_code,
  input wire i_energy_valid,
  input wire [39:0] i_energy_code,
  input wire i_charge_valid,
  input wire [39:0] i_charge_code,
  // outputs
  output reg [39:0] o_rd_data,
  output reg o_rd_valid,
  output reg [13:0] o_temp_coefficient_field,
  output reg o_range_select,
  output reg [31:0] o_shunt_nv_x8
);

localparam [2:0] IDX_SHUNT = 3'd0;
localparam [2:0] IDX_BUS = 3'd1;
localparam [2:0] IDX_TEMP = 3'd2;
localparam [2:0] IDX_CURRENT = 3'd3;
localparam [2:0] IDX_POWER = 3'd4;
localparam [2:0] IDX_ENERGY = 3'd5;
localparam [2:0] IDX_CHARGE = 3'd6;

reg [13:0] temp_coefficient_reg;
reg rd_coef_reg;
reg [2:0] rd_idx_reg;
reg rd_pend_reg;
reg rd_hit_reg;
reg wr_en;
reg [2:0] wr_idx;
reg [39:0] wr_data;
wire [39:0] mem_rd_data;
wire cur_valid;
wire [19:0] cur_code;
wire [31:0] nv_x8;
wire [2:0] rd_idx;
wire rd_hit;

////////////////////////////////////////////////////////////////////////
function [2:0] addr_to_idx;
  input [7:0] a;
  begin
    addr_to_idx = a[2:0] - 3'd4;
    if (a == `PMR_ADDR_SHUNT) begin
      addr_to_idx = IDX_SHUNT;
    end else if (a == `PMR_ADDR_BUS) begin
      addr_to_idx = IDX_BUS;
    end else if (a == `PMR_ADDR_TEMP) begin
      addr_to_idx = IDX_TEMP;
    end else if (a == `PMR_ADDR_CURRENT) begin
      addr_to_idx = IDX_CURRENT;
    end else if (a == `PMR_ADDR_POWER) begin
      addr_to_idx = IDX_POWER;
    end else if (a == `PMR_ADDR_ENERGY) begin
      addr_to_idx = IDX_ENERGY;
    end else if (a == `PMR_ADDR_CHARGE) begin
      addr_to_idx = IDX_CHARGE;
    end else begin
      addr_to_idx = 3'd7;
    end
  end
endfunction

// coefficient address decode, used by write and read
function is_coef_addr;
  input [7:0] a;
  begin
    is_coef_addr = (a == `PMR_ADDR_COEF);
  end
endfunction

// mask of implemented bits per result word
function [39:0] field_mask;
  input [2:0] idx;
  begin
    if (idx == IDX_SHUNT) begin
      field_mask = 40'h0000FFFFF0;
    end else if (idx == IDX_BUS) begin
      field_mask = 40'h0000FFFFF0;
    end else if (idx == IDX_TEMP) begin
      field_mask = 40'h000000FFFF;
    end else if (idx == IDX_CURRENT) begin
      field_mask = 40'h0000FFFFF0;
    end else if (idx == IDX_POWER) begin
      field_mask = 40'h0000FFFFFF;
    end else if (idx == IDX_ENERGY) begin
      field_mask = 40'hFFFFFFFFFF;
    end else if (idx == IDX_CHARGE) begin
      field_mask = 40'hFFFFFFFFFF;
    end else begin
      field_mask = 40'h0000000000;
    end
  end
endfunction

assign rd_idx = addr_to_idx(i_addr);
assign rd_hit = (rd_idx != 3'd7);

////////////////////////////////////////////////////////////////////////
pmr_shunt_scale u_scale (
  .i_clk(i_clk),
  .i_reset_n(i_reset_n),
  .i_valid(i_shunt_valid),
  .i_range_select(i_range_select),
  .i_shunt_cal(i_shunt_cal),
  .i_shunt_code(i_shunt_code),
  .o_valid(cur_valid),
  .o_shunt_nv_x8(nv_x8),
  .o_current_code(cur_code)
);

////////////////////////////////////////////////////////////////////////
// write mux into result storage, one source per cycle by priority
always @* begin
  wr_en = 1'b1;
  wr_idx = IDX_SHUNT;
  wr_data = 40'h0000000000;
  if (cur_valid) begin
    wr_idx = IDX_CURRENT;
    wr_data = {16'h0000, cur_code, 4'h0};
  end else if (i_shunt_valid) begin
    wr_idx = IDX_SHUNT;
    wr_data = {16'h0000, i_shunt_code, 4'h0};
  end else if (i_bus_valid) begin
    wr_idx = IDX_BUS;
    wr_data = i_bus_code[19] ? 40'h0000000000 :
      {16'h0000, i_bus_code, 4'h0};
  end else if (i_temp_valid) begin
    wr_idx = IDX_TEMP;
    wr_data = {24'h000000, i_temp_code};
  end else if (i_power_valid) begin
    wr_idx = IDX_POWER;
    wr_data = {16'h0000, i_power_code};
  end else if (i_energy_valid) begin
    wr_idx = IDX_ENERGY;
    wr_data = i_energy_code;
  end else if (i_charge_valid) begin
    wr_idx = IDX_CHARGE;
    wr_data = i_charge_code;
  end else begin
    wr_en = 1'b0;
  end
end

pmr_result_mem #(
  .DEPTH(`PMR_NUM_RESULTS),
  .AW(3),
  .DW(40)
) u_mem (
  .i_clk(i_clk),
  .i_reset_n(i_reset_n),
  .i_wr_en(wr_en),
  .i_wr_idx(wr_idx),
  .i_wr_data(wr_data),
  .i_rd_idx(rd_idx),
  .o_rd_data(mem_rd_data)
);

////////////////////////////////////////////////////////////////////////
// coefficient register, bits 13..0 writable
always @(posedge i_clk or negedge i_reset_n) begin
  if (!i_reset_n) begin
    temp_coefficient_reg <= `PMR_COEF_RESET;
  end else if (i_wr_en && is_coef_addr(i_addr)) begin
    temp_coefficient_reg <= i_wr_data[`PMR_COEF_MSB:0];
  end
end

always @(posedge i_clk or negedge i_reset_n) begin
  if (!i_reset_n) begin
    rd_pend_reg <= 1'b0;
    rd_coef_reg <= 1'b0;
    rd_hit_reg <= 1'b0;
    rd_idx_reg <= 3'd7;
    o_temp_coefficient_field <= `PMR_COEF_RESET;
    o_range_select <= 1'b0;
    o_shunt_nv_x8 <= 32'h00000000;
  end else begin
    rd_pend_reg <= i_rd_en;
    rd_coef_reg <= i_rd_en && is_coef_addr(i_addr);
    rd_hit_reg <= i_rd_en && rd_hit;
    rd_idx_reg <= rd_idx;
    o_temp_coefficient_field <= temp_coefficient_reg;
    o_range_select <= i_range_select;
    if (cur_valid) begin
      o_shunt_nv_x8 <= nv_x8;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// reserved and unmapped read zero
always @(posedge i_clk or negedge i_reset_n) begin
  if (!i_reset_n) begin
    o_rd_data <= 40'h0000000000;
    o_rd_valid <= 1'b0;
  end else begin
    o_rd_valid <= rd_pend_reg;
    if (rd_coef_reg) begin
      o_rd_data <= {26'h0000000, temp_coefficient_reg};
    end else if (rd_hit_reg) begin
      // reserved positions forced low whatever was stored
      o_rd_data <= mem_rd_data & field_mask(rd_idx_reg);
    end else begin
      o_rd_data <= 40'h0000000000;
    end
  end
end

endmodule

`default_nettype wire

// ==== pmr_defs.vh ====
// Purpose: constants for the power monitor result register bank
// Assumes: register pointer is the device register address, 8 bits
// Notes: widths in bits; reset values all zero except where given
`ifndef PMR_DEFS_VH
`define PMR_DEFS_VH

`define PMR_ADDR_COEF 8'h03
`define PMR_ADDR_SHUNT 8'h04
`define PMR_ADDR_BUS 8'h05
`define PMR_ADDR_TEMP 8'h06
`define PMR_ADDR_CURRENT 8'h07
`define PMR_ADDR_POWER 8'h08
`define PMR_ADDR_ENERGY 8'h09
`define PMR_ADDR_CHARGE 8'h0A

`define PMR_COEF_MSB 13
`define PMR_COEF_RESET 14'h0000
`define PMR_RES24_LSB 4
`define PMR_RESULT_RESET 40'h0000000000
`define PMR_NUM_RESULTS 7
`define PMR_CAL_RESET 15'h1000

`endif

// ==== pmr_result_mem.v ====
// Purpose: storage for the seven result words, registered read data
// Assumes: one write port from the measurement path, one read port
// Notes: every word clears to zero on reset
`default_nettype none

module pmr_result_mem #(
  parameter DEPTH = 7,
  parameter AW = 3,
  parameter DW = 40
) (
  // clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // write side
  input wire i_wr_en,
  input wire [AW-1:0] i_wr_idx,
  input wire [DW-1:0] i_wr_data,
  // read side
  input wire [AW-1:0] i_rd_idx,
  output reg [DW-1:0] o_rd_data
);

reg [DW-1:0] mem_reg [0:DEPTH-1];

////////////////////////////////////////////////////////////////////////
genvar g;
generate
  for (g = 0; g < DEPTH; g = g + 1) begin : gen_word
    always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        mem_reg[g] <= {DW{1'b0}};
      end else if (i_wr_en && i_wr_idx == g) begin
        mem_reg[g] <= i_wr_data;
      end
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////
always @(posedge i_clk or negedge i_reset_n) begin
  if (!i_reset_n) begin
    o_rd_data <= {DW{1'b0}};
  end else if (i_rd_idx < DEPTH) begin
    o_rd_data <= mem_reg[i_rd_idx];
  end else begin
    o_rd_data <= {DW{1'b0}};
  end
end

endmodule

`default_nettype wire

// ==== pmr_shunt_scale.v ====
// Purpose: converts a shunt code to nanovolts and to a current code
// Assumes: range select and calibration come from outside, live values
// Notes: one cycle of latency, outputs registered
`default_nettype none

module pmr_shunt_scale (
  // clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // inputs
  input wire i_valid,
  input wire i_range_select,
  input wire [14:0] i_shunt_cal,
  input wire [19:0] i_shunt_code,
  // outputs
  output reg o_valid,
  output reg [31:0] o_shunt_nv_x8,
  output reg [19:0] o_current_code
);

wire signed [19:0] code_s;
wire signed [35:0] cur_prod;
wire signed [31:0] nv_x8;

assign code_s = i_shunt_code;
// 312.5 nV is 2500/8, 78.125 nV is 625/8
assign nv_x8 = i_range_select ? code_s * $signed(32'sd625) :
  code_s * $signed(32'sd2500);
// current scales with the calibration constant
assign cur_prod = code_s * $signed({1'b0, i_shunt_cal});

////////////////////////////////////////////////////////////////////////
always @(posedge i_clk or negedge i_reset_n) begin
  if (!i_reset_n) begin
    o_valid <= 1'b0;
    o_shunt_nv_x8 <= 32'h00000000;
    o_current_code <= 20'h00000;
  end else begin
    o_valid <= i_valid;
    if (i_valid) begin
      o_shunt_nv_x8 <= nv_x8;
      o_current_code <= cur_prod[31:12];
    end
  end
end

endmodule

`default_nettype wire

// ==== pmr_result_bank_assertions.sv ====
// Purpose: port checks for the result register bank
// Assumes: one clock, async active low reset
// Notes: bound to every result bank
`default_nettype none
module pmr_result_bank_chk (
  // clock, reset, access
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic i_wr_en,
  input wire logic [15:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic i_range_select,
  // outputs
  input wire logic [39:0] o_rd_data,
  input wire logic o_rd_valid,
  input wire logic [13:0] o_temp_coefficient_field,
  input wire logic o_range_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  a_rd_answer_lat: assert property (i_rd_en |-> ##2 o_rd_valid)
    else $error("read answer late");
  a_valid_has_cause: assert property (o_rd_valid |-> $past(i_rd_en, 2))
    else $error("read answer without request");
  a_coef_reserved: assert property (o_rd_valid &&
    $past(i_addr, 2) == 8'h03 |-> o_rd_data[39:14] == 26'h0)
    else $error("coefficient reserved bits set");
  a_res24_reserved: assert property (o_rd_valid &&
    $past(i_addr, 2) inside {8'h04, 8'h05, 8'h07} |->
    o_rd_data[39:24] == 16'h0 && o_rd_data[3:0] == 4'h0)
    else $error("result reserved bits set");
  a_temp_width: assert property (o_rd_valid &&
    $past(i_addr, 2) == 8'h06 |-> o_rd_data[39:16] == 24'h0)
    else $error("temperature wider than 16 bits");
  a_unmapped_zero: assert property (o_rd_valid &&
    ($past(i_addr, 2) < 8'h03 || $past(i_addr, 2) > 8'h0A) |->
    o_rd_data == 40'h0)
    else $error("unmapped read not zero");
  a_coef_write: assert property (i_wr_en && i_addr == 8'h03 |->
    ##2 o_temp_coefficient_field == $past(i_wr_data[13:0], 2))
    else $error("coefficient write lost");
  a_range_follow: assert property ($past(i_reset_n) |->
    o_range_select == $past(i_range_select))
    else $error("range select copy wrong");
endmodule
bind pmr_result_bank pmr_result_bank_chk u_pmr_result_bank_chk (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
  .i_wr_en(i_wr_en), .i_wr_data(i_wr_data), .i_rd_en(i_rd_en),
  .i_range_select(i_range_select), .o_rd_data(o_rd_data),
  .o_rd_valid(o_rd_valid), .o_range_select(o_range_select),
  .o_temp_coefficient_field(o_temp_coefficient_field));
`default_nettype wire

// ==== pmr_host_model.sv ====
// Purpose: host side, register reads and writes
// Assumes: answer one cycle after the taking edge
// Notes: address and data inverted once released
`default_nettype none
module pmr_host_model (
  // clock
  input wire logic i_clk,
  // register access
  output logic [7:0] o_addr = 8'h00,
  output logic o_wr_en = 1'b0,
  output logic [15:0] o_wr_data = 16'h0000,
  output logic o_rd_en = 1'b0,
  input wire logic [39:0] i_rd_data,
  input wire logic i_rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wr_data <= d;
    o_wr_en <= 1'b1;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_addr <= ~a;
    o_wr_data <= ~d;
  endtask
  task rd(input logic [7:0] a, output logic [39:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd_en <= 1'b1;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    o_addr <= ~a;
    @(posedge i_clk);
    #1;
    d = (i_rd_valid === 1'b1) ? i_rd_data : 40'hEEEEEEEEEE;
  endtask
endmodule
`default_nettype wire

// ==== pmr_result_bank_tb.sv ====
// Purpose: self-checking bench for the result register bank
// Assumes: 100 MHz clock, reset held ten cycles
// Notes: calibration starts at its reset value, then is changed
`default_nettype none
module pmr_result_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic rsel_in = 1'b0;
  logic [14:0] cal = 15'h1000;
  logic [5:0] vld = 6'h00;
  logic [39:0] code = 40'h0;
  logic [7:0] addr;
  logic wr_en, rd_en, rd_valid, rsel;
  logic [15:0] wr_data;
  logic [39:0] rd_data;
  logic [13:0] coef;
  logic [31:0] nv;
  int err_count = 0;
  int n_checks = 0;
  always #5 i_clk = ~i_clk;
  pmr_host_model u_pmr_host_model (.i_clk(i_clk), .o_addr(addr),
    .o_wr_en(wr_en), .o_wr_data(wr_data), .o_rd_en(rd_en),
    .i_rd_data(rd_data), .i_rd_valid(rd_valid));
  pmr_result_bank u_pmr_result_bank (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(addr),
    .i_wr_en(wr_en), .i_wr_data(wr_data), .i_rd_en(rd_en),
    .i_range_select(rsel_in), .i_shunt_cal(cal),
    .i_shunt_valid(vld[0]), .i_shunt_code(code[19:0]),
    .i_bus_valid(vld[1]), .i_bus_code(code[19:0]),
    .i_temp_valid(vld[2]), .i_temp_code(code[15:0]),
    .i_power_valid(vld[3]), .i_power_code(code[23:0]),
    .i_energy_valid(vld[4]), .i_energy_code(code),
    .i_charge_valid(vld[5]), .i_charge_code(code),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .o_temp_coefficient_field(coef), .o_range_select(rsel),
    .o_shunt_nv_x8(nv));
  task chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rc(input logic [7:0] a, input logic [39:0] exp);
    logic [39:0] d;
    u_pmr_host_model.rd(a, d);
    chk(d, exp);
  endtask
  task put(input int n, input logic [39:0] v);
    @(posedge i_clk);
    code <= v;
    vld <= 6'h01 << n;
    @(posedge i_clk);
    vld <= 6'h00;
    code <= ~v;
    repeat (3) @(posedge i_clk);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    i_reset_n <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      rc(a[7:0], 40'h0);
    end
    u_pmr_host_model.wr(8'h03, 16'hFFFF);
    rc(8'h03, 40'h3FFF);
    chk({26'h0, coef}, 40'h3FFF);
    u_pmr_host_model.wr(8'h04, 16'h1234);
    rc(8'h04, 40'h0);
    put(0, 40'hFFFFF);
    chk({8'h0, nv}, 40'hFFFFF63C);
    rc(8'h04, 40'hFFFFF0);
    rc(8'h07, 40'hFFFFF0);
    rsel_in <= 1'b1;
    put(0, 40'h2);
    chk({8'h0, nv}, 40'h4E2);
    chk({39'h0, rsel}, 40'h1);
    cal <= 15'h2000;
    put(0, 40'h3);
    rc(8'h07, 40'h60);
    rc(8'h04, 40'h30);
    put(1, 40'h80000);
    rc(8'h05, 40'h0);
    put(1, 40'h12345);
    rc(8'h05, 40'h123450);
    put(2, 40'h8001);
    rc(8'h06, 40'h8001);
    put(3, 40'hFFFFFF);
    rc(8'h08, 40'hFFFFFF);
    put(4, 40'hFFFFFFFFFF);
    rc(8'h09, 40'hFFFFFFFFFF);
    put(5, 40'h8000000001);
    rc(8'h0A, 40'h8000000001);
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    for (int a = 3; a < 11; a++) begin
      rc(a[7:0], 40'h0);
    end
    end_sim;
  end
  initial begin
    #20000;
    err_count++;
    end_sim;
  end
endmodule
`default_nettype wire
